/* File: rtl/itc_controller.sv */
// interrupt triggered transfer controller with axi4-lite registers and a memory port
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module itc_controller #(
  parameter int SRC_W = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          sAwaddr,
  input  wire logic                sAwvalid,
  output logic                     sAwready,
  input  wire logic [31:0]         sWdata,
  input  wire logic [3:0]          sWstrb,
  input  wire logic                sWvalid,
  output logic                     sWready,
  output logic [1:0]               sBresp,
  output logic                     sBvalid,
  input  wire logic                sBready,
  input  wire logic [7:0]          sAraddr,
  input  wire logic                sArvalid,
  output logic                     sArready,
  output logic [31:0]              sRdata,
  output logic [1:0]               sRresp,
  output logic                     sRvalid,
  input  wire logic                sRready,
  input  wire logic                actReq,
  input  wire logic [SRC_W-1:0]    actSrc,
  output logic                     actAck,
  output logic                     memReq,
  output logic                     memWrite,
  output logic [31:0]              memAddr,
  output logic [1:0]               memSize,
  output logic [31:0]              memWdata,
  input  wire logic                memAck,
  input  wire logic [31:0]         memRdata,
  output logic                     cpuIrq,
  output logic [SRC_W-1:0]         cpuIrqSrc,
  output logic                     eventLink
);
  import itc_pkg::*;

  initial begin
    if (SRC_W < 1 || SRC_W > 8) $error("SRC_W must be 1..8");
  end

  typedef enum {ST_IDLE, ST_VEC, ST_INFO, ST_RD, ST_WR, ST_WB, ST_NEXT} itc_state_t;

  typedef struct packed {
    logic             awHeld;
    logic [7:0]       awAddr;
    logic             wHeld;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic [7:0]       operationControl;
    logic [31:0]      vectorTableBase;
    logic [31:0]      indexTableBase;
    logic [15:0]      sequenceEnable;
    logic [31:0]      addressDisplacement;
    itc_state_t       st;
    logic [2:0]       infoIdx;
    logic [SRC_W-1:0] src;
    logic [SRC_W-1:0] cachedSrc;
    logic             cacheValid;
    logic [31:0]      infoAddr;
    logic [7:0]       modeRegA;
    logic [7:0]       modeRegB;
    logic [7:0]       modeRegC;
    logic [31:0]      srcAddr;
    logic [31:0]      dstAddr;
    logic [15:0]      transferCountA;
    logic [15:0]      blockCount;
    logic [31:0]      nextInfo;
    logic [8:0]       blkLeft;
    logic             firstDatum;
    logic             seqActive;
    logic [31:0]      data;
    logic             chainGo;
    logic             endOfCount;
    logic             busy;
    logic             memReq;
    logic             memWrite;
    logic [31:0]      memAddr;
    logic [1:0]       memSize;
    logic [31:0]      memWdata;
    logic             actAck;
    logic             cpuIrq;
    logic [SRC_W-1:0] cpuIrqSrc;
    logic             eventLink;
  } itc_regs_t;

  itc_regs_t r;
  itc_regs_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] mapAddr(input logic [31:0] a, input logic shortMode);
    mapAddr = shortMode ? {{8{a[23]}}, a[23:0]} : a; // [RULE_10]
  endfunction

  function automatic logic [31:0] unitBytes(input logic [1:0] sz);
    unitBytes = (sz == SZ_LONG) ? 32'h4 : (sz == SZ_WORD) ? 32'h2 : 32'h1; // [RULE_05]
  endfunction

  function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic fix,
                                           input logic inc, input logic [1:0] sz);
    stepAddr = fix ? a : (inc ? a + unitBytes(sz) : a - unitBytes(sz));
  endfunction

  logic [31:0] wMerged;
  logic [31:0] curRd;
  always_comb begin
    curRd = 32'h0;
    case (r.awAddr)
      OFS_CTRL:  curRd = {24'h0, r.operationControl};
      OFS_VBASE: curRd = r.vectorTableBase;
      OFS_IBASE: curRd = r.indexTableBase;
      OFS_SEQEN: curRd = {16'h0, r.sequenceEnable};
      OFS_DISP:  curRd = r.addressDisplacement;
      default:   curRd = 32'h0;
    endcase
    for (int i = 0; i < 4; i++) begin
      wMerged[i*8 +: 8] = r.wStrb[i] ? r.wData[i*8 +: 8] : curRd[i*8 +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        shortM;
    logic [1:0]  md;
    logic [1:0]  sz;
    logic [15:0] cnt;
    logic        cntEnd;
    shortM = r.operationControl[CTL_SHORT];
    md     = r.modeRegA[MRA_MD_LO +: 2];
    sz     = r.modeRegA[MRA_SZ_LO +: 2];
    cnt    = r.transferCountA;
    cntEnd = 1'b0;
    next_r = r;
    next_r.actAck    = 1'b0;
    next_r.cpuIrq    = 1'b0;
    next_r.eventLink = 1'b0;

    // register bus slave: address and data taken in either order
    if (sAwvalid && !r.awHeld) begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = sAwaddr;
    end
    if (sWvalid && !r.wHeld) begin
      next_r.wHeld = 1'b1;
      next_r.wData = sWdata;
      next_r.wStrb = sWstrb;
    end
    if (r.awHeld && r.wHeld && !r.bValid) begin
      next_r.awHeld = 1'b0;
      next_r.wHeld  = 1'b0;
      next_r.bValid = 1'b1;
      next_r.bResp  = RESP_OKAY;
      case (r.awAddr)
        OFS_CTRL:  next_r.operationControl = wMerged[7:0];
        OFS_VBASE: next_r.vectorTableBase =
                     {{4{wMerged[27]}}, wMerged[27:0]} & ~32'h3ff; // [RULE_20]
        OFS_IBASE: next_r.indexTableBase = wMerged & IBASE_KEEP;
        OFS_SEQEN: next_r.sequenceEnable = wMerged[15:0];
        OFS_DISP:  next_r.addressDisplacement = wMerged;
        default:   next_r.bResp = RESP_SLVERR;
      endcase
    end
    if (r.bValid && sBready) next_r.bValid = 1'b0;
    if (sArvalid && !r.rValid) begin
      next_r.rValid = 1'b1;
      next_r.rResp  = RESP_OKAY;
      case (sAraddr)
        OFS_CTRL:   next_r.rData = {24'h0, r.operationControl};
        OFS_VBASE:  next_r.rData = r.vectorTableBase;
        OFS_IBASE:  next_r.rData = r.indexTableBase;
        OFS_SEQEN:  next_r.rData = {16'h0, r.sequenceEnable};
        OFS_DISP:   next_r.rData = r.addressDisplacement;
        OFS_STATUS: next_r.rData = {15'h0, r.seqActive, r.transferCountA};
        default: begin
          next_r.rData = 32'h0;
          next_r.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (r.rValid && sRready) next_r.rValid = 1'b0;

    // transfer engine; module stop freezes it where it stands
    if (!r.operationControl[CTL_STOP]) begin // [RULE_21]
      case (r.st)
        ST_IDLE: begin
          if (actReq && r.operationControl[CTL_ENABLE]) begin // [RULE_01] [RULE_23]
            next_r.actAck = 1'b1;
            next_r.src    = actSrc;
            next_r.busy   = 1'b1;
            if (r.operationControl[CTL_RDSKIP] && r.cacheValid && r.cachedSrc == actSrc) begin
              next_r.st      = ST_RD; // [RULE_13]
              next_r.blkLeft = (md == MD_BLOCK) ? {r.blockCount[7:0] == 8'h0,
                                 r.blockCount[7:0]} : 9'h1; // [RULE_04] [RULE_06] [RULE_07]
            end else begin
              next_r.st      = ST_VEC;
              next_r.memReq  = 1'b1;
              next_r.memWrite = 1'b0;
              next_r.memSize = SZ_LONG;
              next_r.memAddr = mapAddr(r.vectorTableBase +
                               {{(30-SRC_W){1'b0}}, actSrc, 2'h0}, shortM); // [RULE_22]
            end
            if (r.seqActive && r.sequenceEnable[0]) next_r.st = ST_INFO; // [RULE_17]
          end
        end
        ST_VEC: if (memAck) begin
          next_r.infoAddr = memRdata;
          next_r.infoIdx  = 3'h0;
          next_r.memReq   = 1'b0;
          next_r.st       = ST_INFO;
        end
        ST_INFO: begin
          next_r.memReq   = !(memAck && r.memReq);
          next_r.memWrite = 1'b0;
          next_r.memSize  = SZ_LONG;
          if (!r.memReq) next_r.memAddr = mapAddr(r.infoAddr + {27'h0, r.infoIdx, 2'h0}, shortM);
          if (memAck && r.memReq) begin
            case (r.infoIdx)
              3'h0: begin
                next_r.modeRegA = memRdata[31:24];
                next_r.modeRegB = memRdata[23:16];
                next_r.modeRegC = memRdata[15:8];
              end
              3'h1: next_r.srcAddr = memRdata;
              3'h2: next_r.dstAddr = memRdata;
              3'h3: {next_r.transferCountA, next_r.blockCount} = memRdata;
              default: next_r.nextInfo = memRdata;
            endcase
            next_r.infoIdx = r.infoIdx + 3'h1;
            if (r.infoIdx == 3'h4) begin
              next_r.memReq     = 1'b0;
              next_r.cacheValid = 1'b1;
              next_r.cachedSrc  = r.src;
              next_r.firstDatum = !r.seqActive;
              next_r.st         = ST_RD;
              next_r.blkLeft    = (r.modeRegA[MRA_MD_LO +: 2] == MD_BLOCK) ?
                                  {r.blockCount[7:0] == 8'h0, r.blockCount[7:0]} : 9'h1;
              if (r.modeRegC[MRC_IRQSRC]) begin
                next_r.cpuIrq    = 1'b1; // [RULE_11]
                next_r.cpuIrqSrc = r.src;
              end
            end
          end
        end
        ST_RD: begin
          next_r.memReq   = 1'b1;
          next_r.memWrite = 1'b0;
          next_r.memSize  = sz;
          next_r.memAddr  = mapAddr(r.modeRegB[MRB_DISPEN] ?
                            r.srcAddr + r.addressDisplacement : r.srcAddr, shortM); // [RULE_19]
          if (memAck && r.memReq) begin
            next_r.data   = memRdata;
            next_r.memReq = 1'b0;
            next_r.st     = ST_WR;
          end
        end
        ST_WR: begin
          next_r.memReq   = 1'b1;
          next_r.memWrite = 1'b1;
          next_r.memSize  = sz;
          next_r.memAddr  = mapAddr(r.dstAddr, shortM);
          next_r.memWdata = r.data;
          if (memAck && r.memReq) begin
            next_r.memReq  = 1'b0;
            next_r.memWrite = 1'b0;
            next_r.srcAddr = stepAddr(r.srcAddr, r.modeRegA[MRA_SMFIX], r.modeRegA[MRA_SMINC], sz);
            next_r.dstAddr = stepAddr(r.dstAddr, r.modeRegB[MRB_DMFIX], r.modeRegB[MRB_DMINC], sz);
            next_r.blkLeft = r.blkLeft - 9'h1;
            if (md != MD_BLOCK || r.blkLeft == 9'h1) begin
              next_r.eventLink = 1'b1; // [RULE_02] [RULE_12]
              if (md == MD_REPEAT) begin
                cntEnd = (cnt[7:0] == 8'h1); // [RULE_03]
                next_r.transferCountA = cntEnd ? {cnt[15:8], cnt[15:8]} :
                                        {cnt[15:8], cnt[7:0] - 8'h1};
                if (cntEnd) begin
                  if (!r.modeRegA[MRA_SMFIX]) next_r.srcAddr = r.srcAddr - {24'h0,
                    cnt[15:8] - 8'h1} * stepAddr(32'h0, 1'b0, r.modeRegA[MRA_SMINC], sz);
                end
              end else begin
                cntEnd = (cnt == 16'h1);
                next_r.transferCountA = cnt - 16'h1;
              end
              next_r.endOfCount = cntEnd;
              next_r.chainGo = r.modeRegB[MRB_CHEN] &&
                               (!r.modeRegB[MRB_CHSEL] || cntEnd); // [RULE_08] [RULE_09]
              if ((r.modeRegC[MRC_IRQEND] && cntEnd) || !r.modeRegC[MRC_IRQEND]) begin
                next_r.cpuIrq    = r.modeRegC[MRC_IRQEND] ? 1'b1 : r.modeRegA[1]; // [RULE_11]
                next_r.cpuIrqSrc = r.src;
              end
              next_r.st = ST_WB;
              next_r.infoIdx = 3'h1;
            end else next_r.st = ST_RD;
            if (r.firstDatum && r.sequenceEnable[0]) begin
              next_r.firstDatum = 1'b0; // [RULE_16]
              next_r.seqActive  = 1'b1;
              next_r.infoAddr   = r.modeRegB[MRB_INDEX_TABLE_REF] ? // [RULE_18]
                                  r.indexTableBase + {22'h0, r.data[7:0], 2'h0} : r.infoAddr;
            end
          end
        end
        ST_WB: begin
          // write back only the changed fields, unless disabled
          if (r.modeRegA[MRA_WRITEBACK_DISABLE]) begin // [RULE_15]
            next_r.st = ST_NEXT;
          end else if ((r.infoIdx == 3'h1 && r.modeRegA[MRA_SMFIX]) ||
                       (r.infoIdx == 3'h2 && r.modeRegB[MRB_DMFIX])) begin
            next_r.infoIdx = r.infoIdx + 3'h1; // [RULE_14]
          end else if (r.infoIdx == 3'h4) begin
            next_r.memReq = 1'b0;
            next_r.st     = ST_NEXT;
          end else begin
            next_r.memReq   = 1'b1;
            next_r.memWrite = 1'b1;
            next_r.memSize  = SZ_LONG;
            next_r.memAddr  = mapAddr(r.infoAddr + {27'h0, r.infoIdx, 2'h0}, shortM);
            next_r.memWdata = (r.infoIdx == 3'h1) ? r.srcAddr :
                              (r.infoIdx == 3'h2) ? r.dstAddr :
                              {r.transferCountA, r.blockCount};
            if (memAck && r.memReq) begin
              next_r.memReq  = 1'b0;
              next_r.memWrite = 1'b0;
              next_r.infoIdx = r.infoIdx + 3'h1;
            end
          end
        end
        ST_NEXT: begin
          // a sequence continues until its end marker, chains follow the link word
          if (r.seqActive && !r.modeRegB[MRB_SEQUENCE_END] && !r.modeRegB[MRB_DISEL]) begin
            next_r.infoAddr = r.nextInfo;
            next_r.infoIdx  = 3'h0;
            next_r.st       = ST_INFO; // [RULE_17]
          end else if (r.seqActive && !r.modeRegB[MRB_SEQUENCE_END]) begin
            next_r.infoAddr = r.nextInfo;
            next_r.st       = ST_IDLE; // suspended, resumes here [RULE_17]
            next_r.busy     = 1'b0;
          end else if (r.chainGo) begin
            next_r.infoAddr = r.nextInfo;
            next_r.infoIdx  = 3'h0;
            next_r.st       = ST_INFO; // [RULE_08]
          end else begin
            next_r.seqActive = 1'b0;
            next_r.busy      = 1'b0;
            next_r.st        = ST_IDLE;
          end
          next_r.chainGo = 1'b0;
        end
        default: next_r.st = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.sequenceEnable <= SEQEN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign sAwready  = !r.awHeld;
  assign sWready   = !r.wHeld;
  assign sBvalid   = r.bValid;
  assign sBresp    = r.bResp;
  assign sArready  = !r.rValid;
  assign sRvalid   = r.rValid;
  assign sRdata    = r.rData;
  assign sRresp    = r.rResp;
  assign actAck    = r.actAck;
  assign memReq    = r.memReq;
  assign memWrite  = r.memWrite;
  assign memAddr   = r.memAddr;
  assign memSize   = r.memSize;
  assign memWdata  = r.memWdata;
  assign cpuIrq    = r.cpuIrq;
  assign cpuIrqSrc = r.cpuIrqSrc;
  assign eventLink = r.eventLink;
endmodule
`default_nettype wire

/* File: shared/itc_pkg.sv */
// constants for the interrupt triggered transfer controller
// Function
// RULE_01 - one channel per activating source; activation request starts that channel
// RULE_02 - normal mode: one datum moved per request
// RULE_03 - repeat mode: one datum per request, address returns after repeat size
// RULE_04 - block mode: one whole block per request, 1 to 256 data
// RULE_05 - unit sizes byte, word and longword
// RULE_06 - block counter 01h is 1, FFh is 255, 00h is 256
// RULE_07 - normal and repeat modes ignore the block count register
// RULE_08 - chain transfer runs several channels on one activation
// RULE_09 - chain select 0 chains always; 1 only when counter ends
// RULE_10 - short-address mode sign-extends from bit 23; full mode uses 32 bits
// RULE_11 - cpu interrupt on request source, per datum, or at count end
// RULE_12 - event link pulse per datum, or per block in block mode
// RULE_13 - read skip reuses cached transfer information for the same channel
// RULE_14 - write-back skips fixed address fields
// RULE_15 - write-back disable bit b0 of mode A suppresses write-back
// RULE_16 - sequence transfer: first datum selects one of 256 sequences
// RULE_17 - sequence runs whole or suspends, resuming on the next request
// RULE_18 - mode B bit b0 is sequence end, bit b1 index table reference
// RULE_19 - optional displacement added to the source address
// RULE_20 - vector base ignores b31..b28, extends b27, low 10 bits zero
// RULE_21 - module stop halts all operation; here only the transfer engine freezes, the register bus still answers
// RULE_22 - vector table at base indexed by source locates transfer information
// RULE_23 - software configures everything before activations are allowed
package itc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_VBASE    = 8'h04;
  localparam logic [7:0] OFS_IBASE    = 8'h08;
  localparam logic [7:0] OFS_SEQEN    = 8'h0c;
  localparam logic [7:0] OFS_DISP     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  // operation_control fields
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_STOP     = 1;
  localparam int CTL_SHORT    = 2;
  localparam int CTL_RDSKIP   = 3;
  // mode_reg_a fields
  localparam int MRA_WRITEBACK_DISABLE    = 0;
  localparam int MRA_SZ_LO    = 4;
  localparam int MRA_MD_LO    = 6;
  localparam int MRA_SMFIX    = 2;
  localparam int MRA_SMINC    = 3;
  // mode_reg_b fields
  localparam int MRB_SEQUENCE_END    = 0;
  localparam int MRB_INDEX_TABLE_REF     = 1;
  localparam int MRB_DMFIX    = 2;
  localparam int MRB_DMINC    = 3;
  localparam int MRB_DISPEN   = 4;
  localparam int MRB_CHSEL    = 6;
  localparam int MRB_CHEN     = 7;
  localparam int MRB_DISEL    = 5;
  // mode_reg_c fields
  localparam int MRC_IRQEND   = 0;
  localparam int MRC_IRQSRC   = 1;
  // mode encodings
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK  = 2'h2;
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_WORD   = 2'h1;
  localparam logic [1:0] SZ_LONG   = 2'h2;
  // transfer information layout in memory (byte offsets)
  localparam logic [31:0] TI_MODE  = 32'h0000_0000;
  localparam logic [31:0] TI_SRC   = 32'h0000_0004;
  localparam logic [31:0] TI_DST   = 32'h0000_0008;
  localparam logic [31:0] TI_CNT   = 32'h0000_000c;
  localparam logic [31:0] TI_NEXT  = 32'h0000_0010;
  localparam logic [31:0] VBASE_KEEP = 32'h0fff_fc00;
  localparam logic [31:0] IBASE_KEEP = 32'hffff_fffc;
  localparam logic [15:0] SEQEN_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

/* File: tb/itc_controller_bench.sv */
// self-checking bench for the transfer controller
`timescale 1ns/1ps
`default_nettype none
module itc_controller_bench;
  import itc_pkg::*;
  logic        sys_clk, rst, sAwvalid, sWvalid, sBready, sArvalid, sRready, actReq, slow;
  logic [7:0]  sAwaddr, sAraddr, actSrc, cpuIrqSrc;
  logic [31:0] sWdata, sRdata, memAddr, memWdata, memRdata, seed, rd, d[3];
  logic [1:0]  sBresp, sRresp, memSize, rsp;
  logic        sAwready, sWready, sBvalid, sArready, sRvalid, actAck;
  logic        memReq, memWrite, memAck, cpuIrq, eventLink;
  int          err_count, checked, cycles, evCnt, irqCnt, ackCnt, n;
  //////////////////////////////////////////////////////////////////////////////
  itc_controller u_dut (.sys_clk(sys_clk), .rst(rst), .sAwaddr(sAwaddr), .sAwvalid(sAwvalid),
    .sAwready(sAwready), .sWdata(sWdata), .sWstrb(4'hf), .sWvalid(sWvalid), .sWready(sWready),
    .sBresp(sBresp), .sBvalid(sBvalid), .sBready(sBready), .sAraddr(sAraddr),
    .sArvalid(sArvalid), .sArready(sArready), .sRdata(sRdata), .sRresp(sRresp),
    .sRvalid(sRvalid), .sRready(sRready), .actReq(actReq), .actSrc(actSrc), .actAck(actAck),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .cpuIrq(cpuIrq),
    .cpuIrqSrc(cpuIrqSrc), .eventLink(eventLink));
  itc_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .slow(slow), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge sys_clk);
    sAwaddr <= a;
    sWdata <= v;
    sAwvalid <= 1;
    sWvalid <= 1;
    sBready <= 1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (sAwready) aw = 0;
      if (sWready) w = 0;
      sAwvalid <= aw;
      sWvalid <= w;
    end
    while (!sBvalid) @(posedge sys_clk);
    r = sBresp;
    sBready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge sys_clk);
    sAraddr <= a;
    sArvalid <= 1;
    sRready <= 1;
    do @(posedge sys_clk); while (!sArready);
    sArvalid <= 0;
    while (!sRvalid) @(posedge sys_clk);
    v = sRdata;
    r = sRresp;
    sRready <= 0;
  endtask
  // request held until acked; done once the memory port stays quiet
  task automatic act(input logic [7:0] s);
    int q;
    @(posedge sys_clk);
    actReq <= 1;
    actSrc <= s;
    slow <= seed[0];
    do @(posedge sys_clk); while (actAck !== 1'b1);
    actReq <= 0;
    q = 0;
    while (q < 12) begin
      @(posedge sys_clk);
      q = (memReq === 1'b0) ? q + 1 : 0;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // counting on the falling edge keeps it clear of the stimulus edge
  always @(negedge sys_clk) begin
    cycles++;
    if (eventLink === 1'b1) evCnt++;
    if (cpuIrq === 1'b1) irqCnt++;
    if (actAck === 1'b1) ackCnt++;
    if (cycles > 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {rst, sAwvalid, sWvalid, sBready, sArvalid, sRready, actReq, slow} = 8'h80;
    {sAwaddr, sAraddr, actSrc, sWdata} = 56'h0;
    seed = 32'h5b5b;
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    axw(OFS_VBASE, 32'hffff_ffff, rsp);
    axr(OFS_VBASE, rd, rsp);
    chk("vector base", 32'hffff_fc00, rd);
    axw(OFS_VBASE, 32'h1234_5678, rsp);
    axr(OFS_VBASE, rd, rsp);
    chk("vector base", 32'h0234_5400, rd);
    axw(8'h40, seed, rsp);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axr(8'h40, rd, rsp);
    chk("unmapped read", 32'h0, rd);
    seed = lfsr(seed);
    axw(OFS_DISP, seed, rsp);
    axr(OFS_DISP, rd, rsp);
    chk("displacement", seed, rd);
    // normal mode, longword, both addresses increment, irq at count end
    axw(OFS_VBASE, 32'h0000_1000, rsp);
    u_mem.mem[32'h1014] = 32'h2000;
    u_mem.mem[32'h2000] = 32'h2808_0100;
    u_mem.mem[32'h2004] = 32'h3000;
    u_mem.mem[32'h2008] = 32'h4000;
    u_mem.mem[32'h200c] = 32'h0003_5555;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      u_mem.mem[32'h3000 + 4 * i] = seed;
      u_mem.mem[32'h4000 + 4 * i] = 32'h0;
      if (i < 3) d[i] = seed;
    end
    axw(OFS_CTRL, 32'h1, rsp);
    for (int i = 0; i < 3; i++) begin
      act(8'd5);
      chk("dest datum", d[i], u_mem.mem[32'h4000 + 4 * i]);
      chk("next dest", 32'h0, u_mem.mem[32'h4004 + 4 * i]);
      chk("source wb", 32'h3004 + 4 * i, u_mem.mem[32'h2004]);
      chk("count wb", 2 - i, u_mem.mem[32'h200c][31:16]);
      chk("events", i + 1, evCnt);
      chk("irqs", i / 2, irqCnt);
    end
    u_mem.mem[32'h2000] = 32'h6808_0000;
    u_mem.mem[32'h200c] = 32'h0202_0000;
    repeat (2) act(8'd5);
    chk("repeat return", 32'h300c, u_mem.mem[32'h2004]);
    // block of two with write-back off, requested while module stopped
    u_mem.mem[32'h1018] = 32'h2100;
    u_mem.mem[32'h2100] = 32'ha908_0000;
    u_mem.mem[32'h2104] = 32'h3000;
    u_mem.mem[32'h2108] = 32'h5000;
    u_mem.mem[32'h210c] = 32'h0001_0002;
    u_mem.mem[32'h5008] = 32'h0;
    axw(OFS_CTRL, 32'h3, rsp);
    n = ackCnt;
    actReq <= 1;
    actSrc <= 8'd6;
    repeat (40) @(posedge sys_clk);
    chk("stopped ack", n, ackCnt);
    fork
      act(8'd6);
      axw(OFS_CTRL, 32'h1, rsp);
    join
    chk("block datum", d[1], u_mem.mem[32'h5004]);
    chk("block end", 32'h0, u_mem.mem[32'h5008]);
    chk("no write-back", 32'h0001_0002, u_mem.mem[32'h210c]);
    chk("block events", 6, evCnt);
    complete_run();
  end
endmodule
bind itc_controller itc_controller_chk u_chk (.sys_clk(sys_clk), .rst(rst), .sBvalid(sBvalid),
  .sBready(sBready), .sBresp(sBresp), .sRvalid(sRvalid), .sRready(sRready), .sRdata(sRdata),
  .actReq(actReq), .actAck(actAck), .memReq(memReq), .memAck(memAck), .memWrite(memWrite),
  .memAddr(memAddr), .memWdata(memWdata), .cpuIrq(cpuIrq), .eventLink(eventLink));
`default_nettype wire

/* File: tb/itc_controller_chk.sv */
// port checker for the transfer controller
`timescale 1ns/1ps
`default_nettype none
module itc_controller_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        sBvalid,
  input wire logic        sBready,
  input wire logic [1:0]  sBresp,
  input wire logic        sRvalid,
  input wire logic        sRready,
  input wire logic [31:0] sRdata,
  input wire logic        actReq,
  input wire logic        actAck,
  input wire logic        memReq,
  input wire logic        memAck,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic        cpuIrq,
  input wire logic        eventLink
);
  import itc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  a_ack_cause: assert property (actAck |-> $past(actReq))
    else $error("ack without a request");
  a_ack_pulse: assert property (actAck |=> !actAck)
    else $error("ack longer than one cycle");
  a_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memWrite) && $stable(memWdata)) else $error("memory request changed");
  a_mem_release: assert property (memReq && memAck |=> !memReq)
    else $error("memory request held after ack");
  a_wr_resp: assert property (sBvalid && !sBready |=> sBvalid && $stable(sBresp))
    else $error("write response dropped");
  a_rd_resp: assert property (sRvalid && !sRready |=> sRvalid && $stable(sRdata))
    else $error("read response dropped");
  a_event_pulse: assert property (eventLink |=> !eventLink)
    else $error("event link too long");
  a_irq_pulse: assert property (cpuIrq |=> !cpuIrq)
    else $error("interrupt too long");
  c_irq: cover property (cpuIrq);
  c_event: cover property (eventLink);
  c_slverr: cover property (sBvalid && sBresp == RESP_SLVERR);
endmodule
`default_nettype wire

/* File: tb/itc_mem_model.sv */
// memory model answering the controller's memory port
`timescale 1ns/1ps
`default_nettype none
module itc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] mem [logic [31:0]];
  int          waitCnt;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    // read data is only valid with ack; otherwise it toggles so stale use shows
    memRdata <= rst ? 32'h0 : ~memRdata;
    if (rst || !memReq || memAck) begin
      waitCnt <= 0;
    end else if (waitCnt < (slow ? 3 : 0)) begin
      waitCnt <= waitCnt + 1;
    end else begin
      memAck <= 1'b1;
      if (memWrite) begin
        mem[memAddr] = memWdata;
      end else begin
        memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
      end
    end
  end
endmodule
`default_nettype wire
